// [inc/opc_cfg.svh]
// timing, field and encoding constants for the output pairing decoder
`ifndef OPC_CFG_SVH
`define OPC_CFG_SVH

// ---------------------------------------------------------------
// register fields and reset values
// ---------------------------------------------------------------
`define OPC_CFG_RESET 8'h00
`define OPC_TBL_MASK 8'h8F
`define OPC_ENC_QUAD 8'h08
`define OPC_ENC_PAIR_ONE 8'h02
`define OPC_ENC_PAIR_TWO 8'h04
`define OPC_ENC_TRIPLE 8'h8C
`define OPC_ENC_HS_A 8'h33
`define OPC_ENC_HS_B 8'h36
`define OPC_PAR_DIS_RESET 1'b1

// ---------------------------------------------------------------
// channel indices, ch21 is index 0
// ---------------------------------------------------------------
`define OPC_CH21 3'h0
`define OPC_CH22 3'h1
`define OPC_CH23 3'h2
`define OPC_CH24 3'h3
`define OPC_CH25 3'h4
`define OPC_CH26 3'h5
`define OPC_CH27 3'h6
`define OPC_CH28 3'h7

// ---------------------------------------------------------------
// fault codes, two bits per channel
// ---------------------------------------------------------------
`define OPC_FLT_NONE 2'h0
`define OPC_FLT_GND 2'h1
`define OPC_FLT_OPEN 2'h2
`define OPC_FLT_OVC 2'h3

// ---------------------------------------------------------------
// overcurrent filter timing
// ---------------------------------------------------------------
`define OPC_CLK_MHZ 200
`define OPC_OVC_SINGLE_NS 4000
`define OPC_OVC_SINGLE_CYC ((`OPC_OVC_SINGLE_NS * `OPC_CLK_MHZ) / 1000)
`define OPC_OVC_PAIRED_CYC (2 * `OPC_OVC_SINGLE_CYC)

`endif

// [inc/opc_pkg.sv]
// types shared by the output pairing decoder
package opc_pkg;
    // decoded pairing modes
    typedef enum logic [2:0] {
        OPC_SINGLE   = 3'b000,
        OPC_QUAD     = 3'b001,
        OPC_PAIR_ONE = 3'b010,
        OPC_PAIR_TWO = 3'b011,
        OPC_TRIPLE   = 3'b100,
        OPC_HS_A     = 3'b101,
        OPC_HS_B     = 3'b110
    } opc_mode_t;

    typedef logic [1:0] opc_fault_t;
endpackage

// [logic/opc_chan_diag.sv]
// per-channel fault latch with overcurrent filter
`timescale 1ns/10ps
`include "opc_cfg.svh"

module opc_chan_diag #(
    parameter int OVC_SINGLE_CYC = `OPC_OVC_SINGLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // analog comparator pins, asynchronous
    input wire logic ovc_pin,
    input wire logic open_pin,
    input wire logic gnd_pin,
    // control
    input wire logic drv_on,
    input wire logic paired,
    input wire logic diag_read,
    // latched fault
    output opc_pkg::opc_fault_t fault_code
);
    logic [2:0] sync1_ff, sync2_ff;
    logic [11:0] ovc_cnt_ff, nxt_ovc_cnt;
    opc_pkg::opc_fault_t code_ff, nxt_code;
    logic [11:0] ovc_limit;
    logic ovc_valid;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {ovc_pin, open_pin, gnd_pin};
            sync2_ff <= sync1_ff;
        end
    end

    // ---------------------------------------------------------------
    // filter and latch
    // ---------------------------------------------------------------
    // doubled filter when paired
    assign ovc_limit = paired ? 12'(2 * OVC_SINGLE_CYC) : 12'(OVC_SINGLE_CYC);
    assign ovc_valid = (ovc_cnt_ff == ovc_limit - 12'h001);

    always_comb begin
        nxt_ovc_cnt = ovc_cnt_ff;
        nxt_code = code_ff;
        // counter restarts whenever the condition drops or driver is off
        if (drv_on && sync2_ff[2]) begin
            if (!ovc_valid) begin
                nxt_ovc_cnt = ovc_cnt_ff + 12'h001;
            end
        end else begin
            nxt_ovc_cnt = 12'h000;
        end
        if (diag_read) begin
            nxt_code = `OPC_FLT_NONE;
        end
        // set wins over read, on-state fault overwrites
        if (drv_on && ovc_valid) begin
            nxt_code = `OPC_FLT_OVC;
        // off thresholds never depend on pairing
        end else if (!drv_on && code_ff == `OPC_FLT_NONE) begin
            if (sync2_ff[1]) begin
                nxt_code = `OPC_FLT_OPEN;
            end else if (sync2_ff[0]) begin
                nxt_code = `OPC_FLT_GND;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ovc_cnt_ff <= 12'h000;
            code_ff <= `OPC_FLT_NONE;
        end else begin
            ovc_cnt_ff <= nxt_ovc_cnt;
            code_ff <= nxt_code;
        end
    end

    assign fault_code = code_ff;
endmodule

// [logic/opc_pairing_decoder.sv]
// pairing register, group decode, command fan-out and diagnosis routing
`timescale 1ns/10ps
`include "opc_cfg.svh"

module opc_pairing_decoder #(
    parameter int NCH = 8,
    parameter int OVC_SINGLE_CYC = `OPC_OVC_SINGLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pairing register access from the serial interface logic
    input wire logic cfg_wr_en,
    input wire logic [7:0] cfg_wr_data,
    output logic [7:0] cfg_rd_data,
    // bit 4 of global_config_seven, same clock domain
    input wire logic par_disable,
    // per-channel commands, index 0 is ch21
    input wire logic [NCH-1:0] channel_command,
    // diagnosis read strobe, one cycle
    input wire logic diag_read,
    // analog comparator pins per channel
    input wire logic [NCH-1:0] ovc_pin,
    input wire logic [NCH-1:0] open_pin,
    input wire logic [NCH-1:0] gnd_pin,
    // driver gates and status
    output logic [NCH-1:0] drv_on,
    output logic [NCH-1:0] paired,
    output logic [2*NCH-1:0] diag_code,
    output opc_pkg::opc_mode_t mode
);
    logic [7:0] cfg_ff, nxt_cfg;
    opc_pkg::opc_mode_t mode_ff, nxt_mode;
    logic [NCH-1:0] drv_ff, nxt_drv;
    logic [NCH-1:0] paired_ff, nxt_paired;
    logic [2*NCH-1:0] diag_ff, nxt_diag;
    logic [2:0] src [NCH];
    logic [NCH-1:0] rpt;
    logic [NCH-1:0] grp;
    opc_pkg::opc_fault_t code [NCH];

    // ---------------------------------------------------------------
    // pairing register
    // ---------------------------------------------------------------
    always_comb begin
        nxt_cfg = cfg_ff;
        if (cfg_wr_en) begin
            nxt_cfg = cfg_wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_ff <= `OPC_CFG_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign cfg_rd_data = cfg_ff;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    // full-value encodings are checked first, they are never table hits
    always_comb begin
        nxt_mode = opc_pkg::OPC_SINGLE;
        if (cfg_ff == `OPC_ENC_HS_A) begin
            nxt_mode = opc_pkg::OPC_HS_A;
        end else if (cfg_ff == `OPC_ENC_HS_B) begin
            nxt_mode = opc_pkg::OPC_HS_B;
        end else if (!par_disable) begin
            case (cfg_ff & `OPC_TBL_MASK)
                `OPC_ENC_QUAD: begin
                    nxt_mode = opc_pkg::OPC_QUAD;
                end
                `OPC_ENC_PAIR_ONE: begin
                    nxt_mode = opc_pkg::OPC_PAIR_ONE;
                end
                `OPC_ENC_PAIR_TWO: begin
                    nxt_mode = opc_pkg::OPC_PAIR_TWO;
                end
                `OPC_ENC_TRIPLE: begin
                    nxt_mode = opc_pkg::OPC_TRIPLE;
                end
                default: begin
                    nxt_mode = opc_pkg::OPC_SINGLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_ff <= opc_pkg::OPC_SINGLE;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign mode = mode_ff;

    // ---------------------------------------------------------------
    // group map: command source and reporting channel
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            src[i] = 3'(i);
        end
        rpt = {NCH{1'b0}};
        case (mode_ff)
            opc_pkg::OPC_QUAD: begin
                src[`OPC_CH22] = `OPC_CH24;
                src[`OPC_CH27] = `OPC_CH24;
                src[`OPC_CH28] = `OPC_CH24;
                rpt[`OPC_CH22] = 1'b1;
            end
            opc_pkg::OPC_PAIR_ONE: begin
                src[`OPC_CH22] = `OPC_CH24;
                rpt[`OPC_CH22] = 1'b1;
            end
            opc_pkg::OPC_PAIR_TWO: begin
                src[`OPC_CH22] = `OPC_CH24;
                src[`OPC_CH28] = `OPC_CH27;
                rpt[`OPC_CH22] = 1'b1;
                rpt[`OPC_CH27] = 1'b1;
            end
            opc_pkg::OPC_TRIPLE: begin
                src[`OPC_CH27] = `OPC_CH24;
                src[`OPC_CH28] = `OPC_CH24;
                rpt[`OPC_CH24] = 1'b1;
            end
            opc_pkg::OPC_HS_A: begin
                src[`OPC_CH22] = `OPC_CH24;
                src[`OPC_CH26] = `OPC_CH25;
                rpt[`OPC_CH22] = 1'b1;
                rpt[`OPC_CH25] = 1'b1;
            end
            opc_pkg::OPC_HS_B: begin
                src[`OPC_CH21] = `OPC_CH23;
                src[`OPC_CH28] = `OPC_CH27;
                rpt[`OPC_CH23] = 1'b1;
                rpt[`OPC_CH27] = 1'b1;
            end
            default: begin
                rpt = {NCH{1'b0}};
            end
        endcase
    end

    // ---------------------------------------------------------------
    // per-channel fan-out, grouping and diagnosis
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            // a channel is grouped when any other shares its command source
            always_comb begin
                grp[g] = 1'b0;
                for (int j = 0; j < NCH; j++) begin
                    if (j != g && src[j] == src[g]) begin
                        grp[g] = 1'b1;
                    end
                end
            end

            opc_chan_diag #(
                .OVC_SINGLE_CYC(OVC_SINGLE_CYC)
            ) u_diag (
                .core_clk(core_clk),
                .reset(reset),
                .ovc_pin(ovc_pin[g]),
                .open_pin(open_pin[g]),
                .gnd_pin(gnd_pin[g]),
                .drv_on(drv_ff[g]),
                .paired(paired_ff[g]),
                .diag_read(diag_read),
                .fault_code(code[g])
            );

            always_comb begin
                // group command drives every member
                nxt_drv[g] = channel_command[src[g]];
                nxt_paired[g] = grp[g];
                nxt_diag[2*g +: 2] = code[g];
                if (grp[g]) begin
                    // reporter shows the worst member, others read clean
                    nxt_diag[2*g +: 2] = `OPC_FLT_NONE;
                    if (rpt[g]) begin
                        for (int j = 0; j < NCH; j++) begin
                            if (src[j] == src[g] && code[j] > nxt_diag[2*g +: 2]) begin
                                nxt_diag[2*g +: 2] = code[j];
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // registered driver gates; host keeps high and low sides apart
    // relies on the host never overlapping paths
    always_ff @(posedge core_clk) begin
        if (reset) begin
            drv_ff <= {NCH{1'b0}};
            paired_ff <= {NCH{1'b0}};
            diag_ff <= {2*NCH{1'b0}};
        end else begin
            drv_ff <= nxt_drv;
            paired_ff <= nxt_paired;
            diag_ff <= nxt_diag;
        end
    end

    assign drv_on = drv_ff;
    assign paired = paired_ff;
    assign diag_code = diag_ff;
endmodule

// [verif/opc_pairing_checker.sv]
// port assertions for the output pairing decoder
`timescale 1ns/10ps
module opc_pairing_checker #(
    parameter int NCH = 8,
    parameter int OVC_SINGLE_CYC = 800
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register, commands and pins
    input wire logic cfg_wr_en,
    input wire logic [7:0] cfg_wr_data,
    input wire logic [7:0] cfg_rd_data,
    input wire logic par_disable,
    input wire logic [NCH-1:0] channel_command,
    input wire logic diag_read,
    input wire logic [NCH-1:0] ovc_pin,
    input wire logic [NCH-1:0] open_pin,
    input wire logic [NCH-1:0] gnd_pin,
    // decoded outputs
    input wire logic [NCH-1:0] drv_on,
    input wire logic [NCH-1:0] paired,
    input wire logic [2*NCH-1:0] diag_code,
    input wire opc_pkg::opc_mode_t mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ---------------------------------------------------------------
    // register and group decode
    // ---------------------------------------------------------------
    a_reg_write: assert property (
        cfg_wr_en |=> cfg_rd_data == $past(cfg_wr_data)) else $error("write not taken");
    a_reg_hold: assert property (
        !cfg_wr_en |=> $stable(cfg_rd_data)) else $error("register changed unwritten");
    a_single_follow: assert property (
        mode == opc_pkg::OPC_SINGLE |=> drv_on == $past(channel_command) && paired == '0)
        else $error("single driver not on its own command");
    a_quad_group: assert property (
        mode == opc_pkg::OPC_QUAD |=> paired == 8'hCA
        && (drv_on & 8'hCA) == ($past(channel_command[3]) ? 8'hCA : 8'h00))
        else $error("quad group wrong");
    a_triple_group: assert property (
        mode == opc_pkg::OPC_TRIPLE |=> paired == 8'hC8
        && (drv_on & 8'hC8) == ($past(channel_command[3]) ? 8'hC8 : 8'h00))
        else $error("triple group wrong");
    a_hsb_group: assert property (
        mode == opc_pkg::OPC_HS_B |=> paired == 8'hC5 && drv_on[0] == $past(channel_command[2])
        && drv_on[7] == $past(channel_command[6])) else $error("paired groups wrong");
    a_hsb_latency: assert property (
        cfg_wr_en && cfg_wr_data == 8'h36 ##1 !cfg_wr_en |=> mode == opc_pkg::OPC_HS_B)
        else $error("mode late after write");
    a_table_off: assert property (
        cfg_wr_en && cfg_wr_data == 8'h08 && par_disable ##1 !cfg_wr_en && par_disable
        |=> mode == opc_pkg::OPC_SINGLE) else $error("table used while disabled");

    // main scenarios reached
    c_quad: cover property (mode == opc_pkg::OPC_QUAD);
    c_hsb: cover property (mode == opc_pkg::OPC_HS_B);
    c_ovc: cover property (diag_code[3:2] == 2'h3);
endmodule

bind opc_pairing_decoder opc_pairing_checker #(.NCH(NCH), .OVC_SINGLE_CYC(OVC_SINGLE_CYC))
    opc_pairing_checker_inst (.core_clk(core_clk), .reset(reset), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .par_disable(par_disable),
    .channel_command(channel_command), .diag_read(diag_read), .ovc_pin(ovc_pin),
    .open_pin(open_pin), .gnd_pin(gnd_pin), .drv_on(drv_on), .paired(paired),
    .diag_code(diag_code), .mode(mode));

// [verif/output_pairing_config_decoder_test.sv]
// self-checking bench for the output pairing decoder
`timescale 1ns/10ps
module output_pairing_config_decoder_test;
    // short filter keeps the overcurrent runs brief
    localparam int OVC = 4;
    localparam logic [7:0] CFG_TAB [10] = '{8'h00, 8'h08, 8'h08, 8'h02, 8'h04,
        8'h8C, 8'h33, 8'h36, 8'h01, 8'h0F};
    localparam logic [9:0] PD_TAB = 10'h084;
    logic core_clk = 1'b0;
    logic reset, cfg_wr_en, par_disable, diag_read;
    logic [7:0] cfg_wr_data, cfg_rd_data, channel_command, ovc_pin, open_pin, gnd_pin;
    logic [7:0] drv_on, paired;
    logic [15:0] diag_code, seed;
    logic [18:0] r;
    opc_pkg::opc_mode_t mode;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int t1, t2;

    opc_pairing_decoder #(.NCH(8), .OVC_SINGLE_CYC(OVC)) opc_pairing_decoder_inst (
        .core_clk(core_clk), .reset(reset), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
        .cfg_rd_data(cfg_rd_data), .par_disable(par_disable),
        .channel_command(channel_command), .diag_read(diag_read), .ovc_pin(ovc_pin),
        .open_pin(open_pin), .gnd_pin(gnd_pin), .drv_on(drv_on), .paired(paired),
        .diag_code(diag_code), .mode(mode));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // cycle ceiling, a hang still ends with a verdict
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // reference model and helpers
    // ---------------------------------------------------------------
    // packed {driver sources, group mask, mode} for one register value
    function automatic logic [18:0] model(input logic [7:0] v, input logic pd,
            input logic [7:0] c);
        if (v == 8'h36) return {c[6], c[6], c[5:3], c[2], c[1], c[2], 8'hC5, 3'h6};
        if (v == 8'h33) return {c[7:6], c[4], c[4:3], c[2], c[3], c[0], 8'h3A, 3'h5};
        if (pd) return {c, 11'h000};
        if ((v & 8'h8F) == 8'h08) return {c[3], c[3], c[5:3], c[2], c[3], c[0], 8'hCA, 3'h1};
        if ((v & 8'h8F) == 8'h02) return {c[7:3], c[2], c[3], c[0], 8'h0A, 3'h2};
        if ((v & 8'h8F) == 8'h04) return {c[6], c[6], c[5:3], c[2], c[3], c[0], 8'hCA, 3'h3};
        if ((v & 8'h8F) == 8'h8C) return {c[3], c[3], c[5:3], c[2:0], 8'hC8, 3'h4};
        return {c, 11'h000};
    endfunction

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] v, input logic pd);
        @(posedge core_clk);
        cfg_wr_en <= 1'b1;
        cfg_wr_data <= v;
        par_disable <= pd;
        @(posedge core_clk);
        cfg_wr_en <= 1'b0;
    endtask

    // bounded wait for a fault on the ch22 reporting slot
    task automatic wait_code(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (diag_code[3:2] === 2'h0 && n < 100);
    endtask

    // pins settle first so that a late synchronised event cannot relatch
    task automatic clear_diag();
        repeat (4) @(posedge core_clk);
        diag_read <= 1'b1;
        @(posedge core_clk);
        diag_read <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check("diag_clear", diag_code, 16'h0000);
    endtask

    task automatic ovc_time(output int n);
        repeat (4) @(posedge core_clk);
        ovc_pin <= 8'h02;
        wait_code(n);
        check("ovc_code", 16'(diag_code[3:2]), 16'h0003);
        @(posedge core_clk);
        ovc_pin <= 8'h00;
        clear_diag();
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {reset, par_disable} = 2'h3;
        {cfg_wr_en, diag_read} = 2'h0;
        {cfg_wr_data, channel_command, ovc_pin, open_pin, gnd_pin} = 40'h0;
        seed = 16'h4A69;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check("rd_reset", 16'(cfg_rd_data), 16'h0000);
        // back-to-back writes, the later value must win
        @(posedge core_clk);
        {cfg_wr_en, cfg_wr_data, par_disable} <= {1'b1, 8'h08, 1'b0};
        @(posedge core_clk);
        cfg_wr_data <= 8'h02;
        wr(8'h02, 1'b0);
        @(negedge core_clk);
        check("rd_b2b", 16'(cfg_rd_data), 16'h0002);
        check("mode_b2b", 16'(mode), 16'h0002);
        // every encoding, each with random commands
        for (int k = 0; k < 10; k++) begin
            wr(CFG_TAB[k], PD_TAB[k]);
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            check("rd_data", 16'(cfg_rd_data), 16'(CFG_TAB[k]));
            for (int n = 0; n < 8; n++) begin
                @(posedge core_clk);
                seed = lfsr(seed);
                channel_command <= seed[7:0];
                @(posedge core_clk);
                @(negedge core_clk);
                r = model(CFG_TAB[k], PD_TAB[k], seed[7:0]);
                check("drv_on", 16'(drv_on), 16'(r[18:11]));
                check("paired", 16'(paired), 16'(r[10:3]));
                check("mode", 16'(mode), 16'(r[2:0]));
            end
            $display("test config %h done", CFG_TAB[k]);
        end
        // filter of a paired stage is longer by one single filter time
        wr(8'h00, 1'b0);
        channel_command <= 8'h02;
        ovc_time(t1);
        wr(8'h08, 1'b0);
        channel_command <= 8'h08;
        ovc_time(t2);
        check("ovc_extra", 16'(t2 - t1), 16'(OVC));
        $display("test overcurrent filter done");
        // off-state open and short together in a group, open wins
        @(posedge core_clk);
        {channel_command, open_pin, gnd_pin} <= {8'h00, 8'h02, 8'h02};
        wait_code(t1);
        check("off_code", 16'(diag_code[3:2]), 16'h0002);
        @(posedge core_clk);
        {open_pin, gnd_pin} <= 16'h0000;
        clear_diag();
        $display("test off-state diagnosis done");
        stop_test();
    end
endmodule
